// ===== dv/bmwg_master_model.sv
// Purpose: modbus master stand-in issuing decoded requests
// Assumes: one request per call, one mclk wide
// Notes:   payload inverted once released
`timescale 1ns/1ps
module bmwg_master_model (
  input  wire logic           mclk,
  input  wire logic           resp_valid,
  input  wire logic [7:0]     resp_exc,
  input  wire logic           fwd_valid,
  output logic                req_valid,
  output bmwg_pkg::bmwg_req_s req,
  output logic                frame_ok
);
  // idle at time zero
  initial begin
    req_valid = 1'b0;
    req       = '0;
    frame_ok  = 1'b0;
  end
  // ==========================================================
  // one request in a valid frame, answer taken a cycle later
  task automatic send(input bmwg_pkg::bmwg_cls_e cls,
                      input logic [31:0] data,
                      output logic [7:0] exc,
                      output logic fwd);
    @(posedge mclk);
    req_valid <= 1'b1;
    req       <= '{cls: cls, data: data};
    frame_ok  <= 1'b1;
    @(posedge mclk);
    req_valid <= 1'b0;
    req.data  <= ~data;
    frame_ok  <= 1'b0;
    @(negedge mclk);
    exc = resp_valid ? resp_exc : 8'hFF;
    fwd = fwd_valid;
  endtask : send
endmodule : bmwg_master_model

// ===== dv/bmwg_top_asserts.sv
// Purpose: port-level checks of the breaker write guard
// Assumes: one mclk domain, async active-high reset
// Notes:   pin history spans the two-stage sync latency
`timescale 1ns/1ps
module bmwg_top_asserts #(
  parameter int unsigned TICK_CYC = 20
) (
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic                req_valid,
  input wire bmwg_pkg::bmwg_req_s req,
  input wire logic                frame_ok,
  input wire logic                resp_valid,
  input wire logic [7:0]          resp_exc,
  input wire logic                fwd_valid,
  input wire bmwg_pkg::bmwg_req_s fwd_req,
  input wire logic                write_permit_input,
  input wire logic                rear_position_switch,
  input wire logic                middle_position_switch,
  input wire logic                front_position_switch,
  input wire logic                operator_output,
  input wire logic                led_green,
  input wire logic                led_red,
  input wire logic [7:0]          slave_addr
);
  // ==========================================================
  // helper history of permit and disconnected pins
  logic [3:0] perm_q;
  logic [3:0] disc_q;
  logic       disc_now;
  logic       guarded;
  assign disc_now = front_position_switch & ~rear_position_switch
                    & ~middle_position_switch;
  assign guarded  = req.cls >= bmwg_pkg::CLS_SWITCH
                    && req.cls <= bmwg_pkg::CLS_MAINT;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      perm_q <= 4'h0;
      disc_q <= 4'h0;
    end else begin
      perm_q <= {perm_q[2:0], write_permit_input};
      disc_q <= {disc_q[2:0], disc_now};
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_addr_default: assert property (
    $fell(reset) |-> slave_addr == bmwg_pkg::SLAVE_ADDR_RST)
    else $error("slave address not at default after reset");
  a_read_served: assert property (
    req_valid && req.cls == bmwg_pkg::CLS_READ |=> resp_valid
    && resp_exc == bmwg_pkg::EXC_NONE && !fwd_valid)
    else $error("read request not served");
  a_prot_refuse: assert property (
    req_valid && guarded && perm_q == 4'h0 && !write_permit_input
    |=> resp_valid && resp_exc == bmwg_pkg::EXC_PROTECT && !fwd_valid)
    else $error("guarded write not refused");
  a_diag_accept: assert property (
    req_valid && req.cls >= bmwg_pkg::CLS_WVTRIG
    |=> resp_exc == bmwg_pkg::EXC_NONE && fwd_valid)
    else $error("diagnostic write refused");
  a_posn_refuse: assert property (
    req_valid && req.cls == bmwg_pkg::CLS_SWITCH && &perm_q
    && write_permit_input && &disc_q && disc_now
    |=> resp_exc == bmwg_pkg::EXC_POSN && !fwd_valid)
    else $error("switching accepted outside connected or test");
  a_out_set: assert property (
    req_valid && req.cls == bmwg_pkg::CLS_USEROUT && req.data[0]
    |-> ##2 operator_output)
    else $error("operator output not set");
  a_out_clr: assert property (
    req_valid && req.cls == bmwg_pkg::CLS_USEROUT
    && req.data[1:0] == 2'b10 |-> ##2 !operator_output)
    else $error("operator output not cleared");
  a_fwd_copy: assert property (
    fwd_valid |-> $past(req_valid) && fwd_req == $past(req))
    else $error("forwarded request differs from taken one");
  a_led_green: assert property (
    frame_ok |-> ##2 led_green && !led_red)
    else $error("indicator not green after valid frame");
  // main scenarios reached
  c_refused: cover property (req_valid && guarded && perm_q == 4'h0);
  c_userout: cover property (req_valid
    && req.cls == bmwg_pkg::CLS_USEROUT);
  c_frame: cover property (frame_ok);
endmodule : bmwg_top_asserts

// ===== dv/tb_bmwg_top.sv
// Purpose: directed bench of the breaker write guard
// Assumes: a ms tick cut to 20 mclk cycles
// Notes:   each scenario judges its own answers
`timescale 1ns/1ps
module tb_bmwg_top;
  localparam int unsigned TCYC = 20;
  logic mclk, reset, reg_wr, reg_rd, req_valid, frame_ok, resp_valid;
  logic fwd_valid, sensor_valid, event_in, write_permit_input, irq;
  logic tripped_signal_switch, rear_position_switch, user_input;
  logic middle_position_switch, front_position_switch;
  logic operator_output, led_green, led_red;
  logic [3:0]          reg_addr;
  logic [15:0]         reg_wdata, reg_rdata, d;
  logic [7:0]          resp_exc, slave_addr;
  bmwg_pkg::bmwg_req_s req, fwd_req;
  bmwg_pkg::bmwg_brk_s sensor_data;
  int                  n_errors, total_checks;
  bmwg_top #(.TICK_CYC(TCYC)) bmwg_top_i (
    .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req_valid, .req, .frame_ok, .resp_valid, .resp_exc, .fwd_valid,
    .fwd_req, .sensor_valid, .sensor_data, .event_in, .write_permit_input,
    .tripped_signal_switch, .rear_position_switch, .middle_position_switch,
    .front_position_switch, .user_input, .operator_output, .led_green,
    .led_red, .slave_addr, .irq);
  bmwg_master_model bmwg_master_model_i (.mclk, .resp_valid, .resp_exc,
    .fwd_valid, .req_valid, .req, .frame_ok);
  // clock
  always #25 mclk = ~mclk;
  // ==========================================================
  // common tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd
  task automatic rq(input bmwg_pkg::bmwg_cls_e c, input logic [31:0] v,
                    input logic [7:0] x);
    logic [7:0] exc;
    logic       fwd;
    bmwg_master_model_i.send(c, v, exc, fwd);
    chk(16'(exc), 16'(x));
    chk(16'(fwd), 16'(x == 8'h00 && c != bmwg_pkg::CLS_READ));
  endtask : rq
  // let pins pass the synchroniser
  task automatic pin_wait;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask : pin_wait
  task automatic setpos(input logic [2:0] v);
    @(posedge mclk);
    {rear_position_switch, middle_position_switch,
     front_position_switch} <= v;
    pin_wait;
    rd(bmwg_pkg::REG_STATUS);
  endtask : setpos
  task automatic trip(input logic v);
    @(posedge mclk);
    tripped_signal_switch <= v;
    pin_wait;
  endtask : trip
  // ==========================================================
  // scenarios
  task automatic t_protect;
    for (int c = 1; c < 15; c++) begin
      rq(bmwg_pkg::bmwg_cls_e'(c), 32'h0, (c < 8) ? 8'h01 : 8'h00);
    end
    rq(bmwg_pkg::CLS_READ, 32'h0, bmwg_pkg::EXC_NONE);
    @(posedge mclk);
    write_permit_input <= 1'b1;
    pin_wait;
    rq(bmwg_pkg::CLS_PROT, 32'h0, bmwg_pkg::EXC_NONE);
  endtask : t_protect
  task automatic t_position;
    setpos(3'b100);
    chk(16'(d[3:0]), 16'(bmwg_pkg::POS_CONN));
    rq(bmwg_pkg::CLS_SWITCH, 32'h1, bmwg_pkg::EXC_NONE);
    setpos(3'b000);
    chk(16'(d[3:0]), 16'(bmwg_pkg::POS_CONN));
    setpos(3'b010);
    chk(16'(d[3:0]), 16'(bmwg_pkg::POS_TEST));
    rq(bmwg_pkg::CLS_SWITCH, 32'h0, bmwg_pkg::EXC_NONE);
    setpos(3'b001);
    chk(16'(d[3:0]), 16'(bmwg_pkg::POS_DISC));
    rq(bmwg_pkg::CLS_SWITCH, 32'h1, bmwg_pkg::EXC_POSN);
  endtask : t_position
  task automatic t_outsrc;
    rq(bmwg_pkg::CLS_USEROUT, 32'h10, bmwg_pkg::EXC_NONE);
    trip(1'b1);
    chk(16'(operator_output), 16'h0001);
    trip(1'b0);
    chk(16'(operator_output), 16'h0000);
    trip(1'b1);
    rq(bmwg_pkg::CLS_USEROUT, 32'h02, bmwg_pkg::EXC_NONE);
    pin_wait;
    chk(16'(operator_output), 16'h0000);
    rq(bmwg_pkg::CLS_USEROUT, 32'h01, bmwg_pkg::EXC_NONE);
    rd(bmwg_pkg::REG_STATUS);
    chk(16'({d[11:10], operator_output}), 16'h0003);
  endtask : t_outsrc
  task automatic t_status;
    @(posedge mclk);
    sensor_valid <= 1'b1;
    sensor_data  <= '{on: 1'b1, spring: 1'b0, ready: 1'b1};
    user_input   <= 1'b1;
    @(posedge mclk);
    sensor_valid <= 1'b0;
    sensor_data  <= '{on: 1'b0, spring: 1'b1, ready: 1'b0};
    pin_wait;
    rd(bmwg_pkg::REG_STATUS);
    chk(16'(d[8:4]), 16'h0015);
  endtask : t_status
  task automatic t_time_irq;
    rq(bmwg_pkg::CLS_TIME, 32'h0001_2345, bmwg_pkg::EXC_NONE);
    rd(bmwg_pkg::REG_TIME_HI);
    chk(d, 16'h0001);
    @(posedge mclk);
    event_in <= 1'b1;
    @(posedge mclk);
    event_in <= 1'b0;
    rd(bmwg_pkg::REG_STMP_HI);
    chk(d, 16'h0001);
    wr(bmwg_pkg::REG_ADDR, 16'h0011);
    @(negedge mclk);
    chk(16'(slave_addr), 16'h0011);
    rd(4'hF);
    chk(d, 16'h0000);
    wr(bmwg_pkg::REG_IRQ_CLR, 16'h000F);
    wr(bmwg_pkg::REG_IRQ_EN, 16'h0004);
    rq(bmwg_pkg::CLS_SWITCH, 32'h0, bmwg_pkg::EXC_POSN);
    repeat (2) @(negedge mclk);
    chk(16'(irq), 16'h0001);
    wr(bmwg_pkg::REG_IRQ_EN, 16'h0000);
    repeat (2) @(negedge mclk);
    chk(16'(irq), 16'h0000);
    wr(bmwg_pkg::REG_IRQ_EN, 16'h0004);
    repeat (2) @(negedge mclk);
    chk(16'(irq), 16'h0001);
    wr(bmwg_pkg::REG_IRQ_CLR, 16'h0004);
    rd(bmwg_pkg::REG_IRQ_ST);
    chk(16'({irq, d[2]}), 16'h0000);
  endtask : t_time_irq
  task automatic t_led;
    wr(bmwg_pkg::REG_WAIT, 16'h0004);
    rq(bmwg_pkg::CLS_READ, 32'h0, bmwg_pkg::EXC_NONE);
    @(negedge mclk);
    chk(16'({led_green, led_red}), 16'h0002);
    repeat (150) @(negedge mclk);
    chk(16'({led_green, led_red}), 16'h0001);
  endtask : t_led
  // verdict and end of run
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // main sequence
  initial begin
    mclk  = 1'b0;
    reset = 1'b1;
    {reg_wr, reg_rd, sensor_valid, event_in, write_permit_input} = '0;
    {tripped_signal_switch, rear_position_switch, user_input} = '0;
    {middle_position_switch, front_position_switch} = '0;
    {reg_addr, reg_wdata, sensor_data} = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk(16'(slave_addr), 16'h007E);
    chk(16'({led_green, led_red}), 16'h0001);
    rd(bmwg_pkg::REG_STATUS);
    chk(16'(d[3:0]), 16'(bmwg_pkg::POS_NONE));
    t_protect;
    t_position;
    t_outsrc;
    t_status;
    t_time_irq;
    t_led;
    finish_test;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    finish_test;
  end
endmodule : tb_bmwg_top
bind bmwg_top bmwg_top_asserts #(.TICK_CYC(TICK_CYC)) bmwg_top_asserts_i (
  .mclk, .reset, .req_valid, .req, .frame_ok, .resp_valid, .resp_exc,
  .fwd_valid, .fwd_req, .write_permit_input, .rear_position_switch,
  .middle_position_switch, .front_position_switch, .operator_output,
  .led_green, .led_red, .slave_addr);

// ===== rtl/bmwg_pkg.sv
// Purpose: constants and types of the breaker write guard
// Assumes: 20 MHz mclk, 16-bit register port
// Notes:   shared by the top module and the bench
package bmwg_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_NS   = 50;
  localparam int unsigned TICK_NS  = 1000000; // one time unit, 1 ms
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  // ==========================================================
  // register indices on the plain port
  localparam logic [3:0] REG_STATUS  = 4'h0;
  localparam logic [3:0] REG_ADDR    = 4'h1;
  localparam logic [3:0] REG_TIME_LO = 4'h2;
  localparam logic [3:0] REG_TIME_HI = 4'h3;
  localparam logic [3:0] REG_STMP_LO = 4'h4;
  localparam logic [3:0] REG_STMP_HI = 4'h5;
  localparam logic [3:0] REG_IRQ_ST  = 4'h6;
  localparam logic [3:0] REG_IRQ_CLR = 4'h7;
  localparam logic [3:0] REG_IRQ_EN  = 4'h8;
  localparam logic [3:0] REG_WAIT    = 4'h9;
  // reset values
  localparam logic [7:0]  SLAVE_ADDR_RST = 8'h7E; // 126
  localparam logic [15:0] WAIT_RST       = 16'h03E8;
  // ==========================================================
  // operator output control byte fields
  localparam int unsigned OC_SET  = 0;
  localparam int unsigned OC_CLR  = 1;
  localparam int unsigned OC_TRIP = 4;
  // position one-hot codes
  localparam logic [3:0] POS_CONN = 4'h1;
  localparam logic [3:0] POS_TEST = 4'h2;
  localparam logic [3:0] POS_DISC = 4'h4;
  localparam logic [3:0] POS_NONE = 4'h8;
  // exception codes
  localparam logic [7:0] EXC_NONE    = 8'h00;
  localparam logic [7:0] EXC_PROTECT = 8'h01;
  localparam logic [7:0] EXC_POSN    = 8'h04;
  // interrupt bits
  localparam int unsigned IRQ_W     = 4;
  localparam int unsigned IRQ_TRIP  = 0;
  localparam int unsigned IRQ_POS   = 1;
  localparam int unsigned IRQ_REF   = 2;
  localparam int unsigned IRQ_TMO   = 3;
  // ==========================================================
  // request classes
  typedef enum logic [3:0] {
    CLS_READ   = 4'h0, CLS_SWITCH = 4'h1, CLS_TRIPRST = 4'h2,
    CLS_PROT   = 4'h3, CLS_XPROT  = 4'h4, CLS_COMM    = 4'h5,
    CLS_MEAS   = 4'h6, CLS_MAINT  = 4'h7, CLS_WVTRIG  = 4'h8,
    CLS_WVREAD = 4'h9, CLS_THRESH = 4'hA, CLS_TIME    = 4'hB,
    CLS_TEXT   = 4'hC, CLS_MINMAX = 4'hD, CLS_USEROUT = 4'hE
  } bmwg_cls_e;
  typedef struct packed {
    bmwg_cls_e   cls;
    logic [31:0] data;
  } bmwg_req_s;
  typedef struct packed {
    logic on;
    logic spring;
    logic ready;
  } bmwg_brk_s;
endpackage : bmwg_pkg

// ===== rtl/bmwg_top.sv
// Purpose: write gating, status and output control of a breaker
//          communication module behind a Modbus slave
// Assumes: requests arrive decoded from the frame layer on mclk
// Notes:   pins pass a two-stage synchroniser
//
// Summary of operation
// - unbridged permit input forbids remote writes
// - protected writes refused while forbidden
// - diagnostic writes still accepted while forbidden
// - reads always served
// - slave address defaults to 126
// - tripped mode: output follows tripped switch
// - control bit 4 without set or clear bit selects tripped mode
// - set or clear bit returns operator mode
// - events time stamped, clock settable remotely
// - switching only in connected or test
// - free user input readable as status
// - breaker status from sensor exposed
// - position decoded one-hot from micro switches
// - no switch actuated keeps old position
// - indicator green after frame until timeout
`timescale 1ns/1ps
module bmwg_top #(
  parameter int unsigned TICK_CYC = bmwg_pkg::TICK_CYC
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  // decoded requests from the frame layer
  input  wire logic               req_valid,
  input  wire bmwg_pkg::bmwg_req_s req,
  input  wire logic               frame_ok,
  output logic                    resp_valid,
  output logic      [7:0]         resp_exc,
  output logic                    fwd_valid,
  output bmwg_pkg::bmwg_req_s     fwd_req,
  // internal breaker bus status
  input  wire logic               sensor_valid,
  input  wire bmwg_pkg::bmwg_brk_s sensor_data,
  input  wire logic               event_in,
  // pins
  input  wire logic               write_permit_input,
  input  wire logic               tripped_signal_switch,
  input  wire logic               rear_position_switch,
  input  wire logic               middle_position_switch,
  input  wire logic               front_position_switch,
  input  wire logic               user_input,
  output logic                    operator_output,
  output logic                    led_green,
  output logic                    led_red,
  output logic      [7:0]         slave_addr,
  output logic                    irq
);
  // ==========================================================
  // declarations
  localparam int unsigned IRQ_W_L = bmwg_pkg::IRQ_W;
  logic [5:0]  sync1_q;
  logic [5:0]  sync2_q;
  logic        permit;
  logic        trip_sw;
  logic        user_in;
  logic [2:0]  pos_sw;
  logic [3:0]  pos_q;
  logic        trip_d1_q;
  bmwg_pkg::bmwg_brk_s brk_q;
  logic        mode_trip_q;
  logic        op_val_q;
  logic [31:0] time_q;
  logic [31:0] stamp_q;
  logic [15:0] tick_q;
  logic        tick;
  logic [15:0] wait_q;
  logic [15:0] wait_cnt_q;
  logic        comm_q;
  logic [IRQ_W_L-1:0] irq_st_q;
  logic [IRQ_W_L-1:0] irq_en_q;
  logic [IRQ_W_L-1:0] irq_ev;
  logic        refused;
  logic        tmo_ev;
  logic        pos_ev;
  logic        trip_ev;
  logic [7:0]  exc_d;
  logic [7:0]  oc_byte;

  // true for classes that write protection blocks
  function automatic logic is_guarded(bmwg_pkg::bmwg_cls_e c);
    case (c)
      bmwg_pkg::CLS_SWITCH, bmwg_pkg::CLS_TRIPRST,
      bmwg_pkg::CLS_PROT, bmwg_pkg::CLS_XPROT,
      bmwg_pkg::CLS_COMM, bmwg_pkg::CLS_MEAS,
      bmwg_pkg::CLS_MAINT: is_guarded = 1'b1;
      default: is_guarded = 1'b0;
    endcase
  endfunction : is_guarded

  // ==========================================================
  // pin synchroniser
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {user_input, front_position_switch,
                  middle_position_switch, rear_position_switch,
                  tripped_signal_switch, write_permit_input};
      sync2_q <= sync1_q;
    end
  end

  assign permit  = sync2_q[0];
  assign trip_sw = sync2_q[1];
  assign pos_sw  = sync2_q[4:2];
  assign user_in = sync2_q[5];

  // ==========================================================
  // position decode
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pos_q <= bmwg_pkg::POS_NONE;
    end else begin
      case (pos_sw)
        3'h1: pos_q <= bmwg_pkg::POS_CONN;
        3'h2: pos_q <= bmwg_pkg::POS_TEST;
        3'h4: pos_q <= bmwg_pkg::POS_DISC;
        default: pos_q <= pos_q;
      endcase
    end
  end

  assign pos_ev = (pos_sw == 3'h1 && pos_q != bmwg_pkg::POS_CONN)
               || (pos_sw == 3'h2 && pos_q != bmwg_pkg::POS_TEST)
               || (pos_sw == 3'h4 && pos_q != bmwg_pkg::POS_DISC);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      brk_q <= '0;
    end else if (sensor_valid) begin
      brk_q <= sensor_data;
    end
  end

  // trip edge detect
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      trip_d1_q <= 1'b0;
    end else begin
      trip_d1_q <= trip_sw;
    end
  end
  assign trip_ev = trip_sw & ~trip_d1_q;

  // ==========================================================
  // request handling
  always_comb begin
    exc_d = bmwg_pkg::EXC_NONE;
    if (req.cls == bmwg_pkg::CLS_READ) begin
      exc_d = bmwg_pkg::EXC_NONE;
    end else if (is_guarded(req.cls) && !permit) begin
      exc_d = bmwg_pkg::EXC_PROTECT;
    end else if (req.cls == bmwg_pkg::CLS_SWITCH &&
                 pos_q != bmwg_pkg::POS_CONN &&
                 pos_q != bmwg_pkg::POS_TEST) begin
      exc_d = bmwg_pkg::EXC_POSN;
    end
  end
  assign refused = req_valid && (exc_d != bmwg_pkg::EXC_NONE);
  assign oc_byte = req.data[7:0];

  // answer and forward to the breaker bus
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      resp_valid <= 1'b0;
      resp_exc   <= bmwg_pkg::EXC_NONE;
      fwd_valid  <= 1'b0;
      fwd_req    <= '0;
    end else begin
      resp_valid <= req_valid;
      fwd_valid  <= 1'b0;
      if (req_valid) begin
        resp_exc <= exc_d;
        if (exc_d == bmwg_pkg::EXC_NONE &&
            req.cls != bmwg_pkg::CLS_READ) begin
          fwd_valid <= 1'b1;
          fwd_req   <= req;
        end
      end
    end
  end

  // ==========================================================
  // operator output source
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_trip_q <= 1'b0;
      op_val_q    <= 1'b0;
    end else if (req_valid &&
                 req.cls == bmwg_pkg::CLS_USEROUT) begin
      // set or clear returns operator mode
      if (oc_byte[bmwg_pkg::OC_SET] |
          oc_byte[bmwg_pkg::OC_CLR]) begin
        mode_trip_q <= 1'b0;
        op_val_q    <= oc_byte[bmwg_pkg::OC_SET];
      end else if (oc_byte[bmwg_pkg::OC_TRIP]) begin
        mode_trip_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      operator_output <= 1'b0;
    end else begin
      operator_output <= mode_trip_q ? trip_sw : op_val_q;
    end
  end

  // ==========================================================
  // system time and event stamps
  assign tick = (tick_q == 16'(TICK_CYC - 1));
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      time_q <= 32'h00000000;
    end else if (req_valid && req.cls == bmwg_pkg::CLS_TIME) begin
      time_q <= req.data;
    end else if (tick) begin
      time_q <= time_q + 32'h00000001;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stamp_q <= 32'h00000000;
    end else if (event_in | trip_ev | pos_ev) begin
      stamp_q <= time_q;
    end
  end

  // ==========================================================
  // communication indicator
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wait_cnt_q <= 16'h0000;
      comm_q     <= 1'b0;
    end else if (frame_ok) begin
      wait_cnt_q <= wait_q;
      comm_q     <= 1'b1;
    end else if (tick && comm_q) begin
      wait_cnt_q <= wait_cnt_q - 16'h0001;
      if (wait_cnt_q <= 16'h0001) begin
        comm_q <= 1'b0;
      end
    end
  end
  assign tmo_ev = tick && comm_q && !frame_ok &&
                  (wait_cnt_q <= 16'h0001);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      led_green <= 1'b0;
      led_red   <= 1'b1;
    end else begin
      led_green <= comm_q;
      led_red   <= ~comm_q;
    end
  end

  // ==========================================================
  // interrupts; a new event wins over a clear
  always_comb begin
    irq_ev = '0;
    irq_ev[bmwg_pkg::IRQ_TRIP] = trip_ev;
    irq_ev[bmwg_pkg::IRQ_POS]  = pos_ev;
    irq_ev[bmwg_pkg::IRQ_REF]  = refused;
    irq_ev[bmwg_pkg::IRQ_TMO]  = tmo_ev;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_st_q <= '0;
    end else if (reg_wr && reg_addr == bmwg_pkg::REG_IRQ_CLR) begin
      irq_st_q <= (irq_st_q & ~reg_wdata[IRQ_W_L-1:0]) | irq_ev;
    end else begin
      irq_st_q <= irq_st_q | irq_ev;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_q & irq_en_q);
    end
  end

  // ==========================================================
  // register writes
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      slave_addr <= bmwg_pkg::SLAVE_ADDR_RST;
      irq_en_q   <= '0;
      wait_q     <= bmwg_pkg::WAIT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        bmwg_pkg::REG_ADDR:   slave_addr <= reg_wdata[7:0];
        bmwg_pkg::REG_IRQ_EN: irq_en_q <= reg_wdata[IRQ_W_L-1:0];
        bmwg_pkg::REG_WAIT:   wait_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register reads, data one cycle later
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        bmwg_pkg::REG_STATUS:
          reg_rdata <= {4'h0, mode_trip_q, op_val_q, permit, user_in,
                        1'b0, brk_q, pos_q};
        bmwg_pkg::REG_ADDR:    reg_rdata <= {8'h00, slave_addr};
        bmwg_pkg::REG_TIME_LO: reg_rdata <= time_q[15:0];
        bmwg_pkg::REG_TIME_HI: reg_rdata <= time_q[31:16];
        bmwg_pkg::REG_STMP_LO: reg_rdata <= stamp_q[15:0];
        bmwg_pkg::REG_STMP_HI: reg_rdata <= stamp_q[31:16];
        bmwg_pkg::REG_IRQ_ST:
          reg_rdata <= {12'h000, irq_st_q};
        bmwg_pkg::REG_IRQ_EN:
          reg_rdata <= {12'h000, irq_en_q};
        bmwg_pkg::REG_WAIT:    reg_rdata <= wait_q;
        default:               reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : bmwg_top
